// ---- tap_cfg.svh ----
`ifndef TAP_CFG_SVH
`define TAP_CFG_SVH

// Instruction register
`define IR_W         3
`define IR_EXTEST    3'h0
`define IR_SAMPLE    3'h1
`define IR_HIGHZ     3'h5
`define IR_CLAMP     3'h6
`define IR_BYPASS    3'h7
`define IR_CAPTURE   3'h1

// Identification register fields, values arbitrary
`define ID_W         32
`define ID_VERSION   4'h1
`define ID_PART      16'h5B1E
`define ID_NUMBER    4'h3
`define ID_LOW_BYTE  8'h01

// Boundary chain: three cells per I/O
`define IO_COUNT     8
`define BSC_PER_IO   3
`define BSC_IN       0
`define BSC_OUT      1
`define BSC_OE       2

// Serial output buffer
`define OUTQ_DEPTH   16
`define OUTQ_W       2

// Link timing
`define CORE_CLK_NS  20
`define TCK_MIN_NS   50
`define TCK_MIN_CYC  ((`TCK_MIN_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define TLR_TMS_RUN  5

`endif

// ---- tap_pkg.sv ----
package tap_pkg;

	typedef enum logic [3:0] {
		ST_E2D = 4'h0, ST_E1D = 4'h1, ST_SDR = 4'h2, ST_PDR = 4'h3,
		ST_SIS = 4'h4, ST_UDR = 4'h5, ST_CDR = 4'h6, ST_SDS = 4'h7,
		ST_E2I = 4'h8, ST_E1I = 4'h9, ST_SIR = 4'hA, ST_PIR = 4'hB,
		ST_RTI = 4'hC, ST_UIR = 4'hD, ST_CIR = 4'hE, ST_TLR = 4'hF
	} tap_state_e;

	typedef logic [2:0] instr_t;

endpackage

// ---- jtag_tap.sv ----
`timescale 1ns/1ps
`include "tap_cfg.svh"

module bit_fifo #(
	parameter int W = 2,
	parameter int D = 16
) (
	input  wire logic         clk,       // Core clock
	input  wire logic         rst_n,     // Synchronous-released reset
	input  wire logic         in_valid,  // Write request
	output logic              in_ready,  // Room available
	input  wire logic [W-1:0] in_data,   // Write word
	output logic              out_valid, // Word available
	input  wire logic         out_ready, // Read request
	output logic [W-1:0]      out_data   // Head word
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;

	assign in_ready  = (cnt_q != D[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rp_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			wp_q  <= push ? AW'(wp_q + 1'b1) : wp_q;
			rp_q  <= pop ? AW'(rp_q + 1'b1) : rp_q;
			cnt_q <= (AW+1)'(cnt_q + push - pop);
		end
	end
endmodule // bit_fifo

// Notes on behaviour
// R01: Controller state is held in a four-bit encoded register.
// R02: Transitions follow mode-select level sampled at each test clock rise.
// R03: After power-up reset the controller sits in Test-Logic-Reset.
// R04: Five test clocks with mode-select high reach Test-Logic-Reset.
// R05: A one-bit bypass register shortens the serial path.
// R06: Identification register is 32 bits: low byte, ID, part, version.
// R07: Every I/O owns three boundary cells: input, output, enable.
// R08: Boundary cells form one chain from data input to data output.
// R09: Parallel side of cells sits between core and pad buffers.
// R10: Serial data and mode-select are taken on test clock rise.
// R11: Serial data output changes on test clock fall.
// R12: Tester keeps the test clock at or below 20 MHz.
// R13: Data output is released unless a shift is in progress.
// R14: Code 000 drives pins from boundary cells and captures inputs.
// R15: Code 001 captures pin snapshot while core keeps the pins.
// R16: Code 101 tristates every I/O.
// R17: Code 110 drives pins from the boundary register.
// R18: Code 111 puts bypass between data input and output.
// R19: Standard sixteen-state graph with capture, shift and update states.
// R20: Codes 010, 011 and 100 behave as bypass.
// R21: Test-Logic-Reset loads bypass code; identification is read out.
module jtag_tap
	import tap_pkg::*;
(
	input  wire logic                   core_clk,  // 50 MHz core clock
	input  wire logic                   resetn,    // Async reset, low
	input  wire logic                   tck,       // Test clock pin
	input  wire logic                   tms,       // Mode-select pin
	input  wire logic                   tdi,       // Serial data in pin
	output logic                        tdo_o,     // Serial data out
	output logic                        tdo_oe_o,  // Data out drive enable
	input  wire logic [`IO_COUNT-1:0]   core_out,  // Core output data
	input  wire logic [`IO_COUNT-1:0]   core_oe,   // Core output enables
	output logic      [`IO_COUNT-1:0]   core_in_o, // Input data to core
	input  wire logic [`IO_COUNT-1:0]   pad_in,    // Pad input levels
	output logic      [`IO_COUNT-1:0]   pad_out_o, // Pad output data
	output logic      [`IO_COUNT-1:0]   pad_oe_o   // Pad output enables
);
	import tap_pkg::*;

	localparam int NB = `IO_COUNT * `BSC_PER_IO;

	logic rst_s1_q, rst_n;
	logic [1:0] tck_s_q, tms_s_q, tdi_s_q;
	logic tck_d_q;
	logic [`IO_COUNT-1:0] pin_s1_q, pin_s_q;
	tap_state_e st_q, st_d;
	instr_t ir_q, ir_sh_q;
	logic id_sel_q, byp_q, pend_q;
	logic [`ID_W-1:0] id_q;
	logic [NB-1:0] bsr_q, upd_q;
	logic oq_rdy, oq_vld;
	logic [`OUTQ_W-1:0] oq_dat;
	logic [2:0] tms_run_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// Pin synchronisers; only stage [1] is read
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tck_s_q  <= 2'h0;
			tms_s_q  <= 2'h3;
			tdi_s_q  <= 2'h0;
			tck_d_q  <= 1'b0;
			pin_s1_q <= '0;
			pin_s_q  <= '0;
		end else begin
			tck_s_q  <= {tck_s_q[0], tck};
			tms_s_q  <= {tms_s_q[0], tms};
			tdi_s_q  <= {tdi_s_q[0], tdi};
			tck_d_q  <= tck_s_q[1];
			pin_s1_q <= pad_in;
			pin_s_q  <= pin_s1_q;
		end
	end

	wire tck_rise = tck_s_q[1] & ~tck_d_q;
	wire tck_fall = ~tck_s_q[1] & tck_d_q;
	wire step     = tck_rise & ~pend_q;
	wire tms_v    = tms_s_q[1];
	wire tdi_v    = tdi_s_q[1];

	always_comb begin
		unique case (st_q) // see R19
			ST_TLR: st_d = tms_v ? ST_TLR : ST_RTI;
			ST_RTI: st_d = tms_v ? ST_SDS : ST_RTI;
			ST_SDS: st_d = tms_v ? ST_SIS : ST_CDR;
			ST_CDR: st_d = tms_v ? ST_E1D : ST_SDR;
			ST_SDR: st_d = tms_v ? ST_E1D : ST_SDR;
			ST_E1D: st_d = tms_v ? ST_UDR : ST_PDR;
			ST_PDR: st_d = tms_v ? ST_E2D : ST_PDR;
			ST_E2D: st_d = tms_v ? ST_UDR : ST_SDR;
			ST_UDR: st_d = tms_v ? ST_SDS : ST_RTI;
			ST_SIS: st_d = tms_v ? ST_TLR : ST_CIR;
			ST_CIR: st_d = tms_v ? ST_E1I : ST_SIR;
			ST_SIR: st_d = tms_v ? ST_E1I : ST_SIR;
			ST_E1I: st_d = tms_v ? ST_UIR : ST_PIR;
			ST_PIR: st_d = tms_v ? ST_E2I : ST_PIR;
			ST_E2I: st_d = tms_v ? ST_UIR : ST_SIR;
			ST_UIR: st_d = tms_v ? ST_SDS : ST_RTI;
		endcase
	end

	// Four-bit state, reset lands in Test-Logic-Reset
	always_ff @(posedge core_clk or negedge rst_n) begin // see R01
		if (!rst_n) begin
			st_q <= ST_TLR; // see R03
		end else if (step) begin
			st_q <= st_d; // see R02 see R04
		end
	end

	// Run of high mode-select steps for the reset check
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) tms_run_q <= 3'h0;
		else if (step) tms_run_q <= !tms_v ? 3'h0
			: (tms_run_q == 3'h7 ? 3'h7 : 3'(tms_run_q + 1'b1));
	end

	reset_state_a: assert property ($rose(rst_n) |-> st_q == ST_TLR) // see R03
		else $error("controller not in reset state after reset");
	tms_five_a: assert property (tms_run_q >= 3'h5 |-> st_q == ST_TLR) // see R04
		else $error("five high mode-select clocks missed reset");
	state_hold_a: assert property (!step |=> $stable(st_q)) // see R02
		else $error("state moved without a test clock rise");

	// Instruction decode
	wire sel_bsr  = ~id_sel_q & (ir_q == `IR_EXTEST | ir_q == `IR_SAMPLE
		| ir_q == `IR_CLAMP);
	wire sel_id   = id_sel_q;
	wire sel_byp  = ~sel_bsr & ~sel_id; // see R18 see R20
	wire drive_bs = ~id_sel_q & (ir_q == `IR_EXTEST | ir_q == `IR_CLAMP);
	wire all_z    = ~id_sel_q & (ir_q == `IR_HIGHZ); // see R16
	wire in_cap   = step & (st_q == ST_CDR);
	wire in_shd   = step & (st_q == ST_SDR);
	wire [`ID_W-1:0] id_val = {`ID_VERSION, `ID_PART, `ID_NUMBER,
		`ID_LOW_BYTE}; // see R06

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ir_q     <= `IR_BYPASS;
			ir_sh_q  <= `IR_CAPTURE;
			id_sel_q <= 1'b1;
		end else if (step && st_q == ST_TLR) begin
			ir_q     <= `IR_BYPASS; // see R21
			id_sel_q <= 1'b1;
		end else if (step && st_q == ST_CIR) begin
			ir_sh_q  <= `IR_CAPTURE;
		end else if (step && st_q == ST_SIR) begin
			ir_sh_q  <= {tdi_v, ir_sh_q[2:1]}; // see R10
		end else if (step && st_q == ST_UIR) begin
			ir_q     <= ir_sh_q;
			id_sel_q <= 1'b0;
		end
	end

	reset_instr_a: assert property (step && st_q == ST_TLR // see R21
		|=> ir_q == `IR_BYPASS && id_sel_q)
		else $error("reset did not load bypass code");

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			byp_q <= 1'b0;
			id_q  <= '0;
		end else begin
			if (in_cap && sel_byp) byp_q <= 1'b0; // see R05
			else if (in_shd && sel_byp) byp_q <= tdi_v;
			if (in_cap && sel_id) id_q <= id_val;
			else if (in_shd && sel_id) id_q <= {tdi_v, id_q[`ID_W-1:1]};
		end
	end

	bypass_cap_a: assert property (in_cap && sel_byp |=> !byp_q) // see R05
		else $error("bypass did not capture zero");

	// Boundary cells: input, output and enable per I/O
	wire [NB-1:0] bsr_cap;
	wire [`IO_COUNT-1:0] upd_in, upd_out, upd_oe;
	genvar gi;
	generate
		for (gi = 0; gi < `IO_COUNT; gi++) begin : g_io // see R07
			assign bsr_cap[gi*`BSC_PER_IO + `BSC_IN]  = pin_s_q[gi];
			assign bsr_cap[gi*`BSC_PER_IO + `BSC_OUT] = core_out[gi];
			assign bsr_cap[gi*`BSC_PER_IO + `BSC_OE]  = core_oe[gi];
			assign upd_in[gi]  = upd_q[gi*`BSC_PER_IO + `BSC_IN];
			assign upd_out[gi] = upd_q[gi*`BSC_PER_IO + `BSC_OUT];
			assign upd_oe[gi]  = upd_q[gi*`BSC_PER_IO + `BSC_OE];
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bsr_q <= '0;
			upd_q <= '0;
		end else begin
			if (in_cap && sel_bsr) bsr_q <= bsr_cap; // see R15
			else if (in_shd && sel_bsr)
				bsr_q <= {tdi_v, bsr_q[NB-1:1]}; // see R08
			if (step && st_q == ST_UDR && sel_bsr) upd_q <= bsr_q;
		end
	end

	// Pad and core sides of the cells
	wire [`IO_COUNT-1:0] pad_out_d = drive_bs ? upd_out : core_out;
	wire [`IO_COUNT-1:0] pad_oe_d  = all_z ? '0
		: (drive_bs ? upd_oe : core_oe); // see R14 see R17
	wire [`IO_COUNT-1:0] core_in_d = (~id_sel_q & ir_q == `IR_EXTEST)
		? upd_in : pin_s_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_out_o <= '0;
			pad_oe_o  <= '0;
			core_in_o <= '0;
		end else begin
			pad_out_o <= pad_out_d; // see R09
			pad_oe_o  <= pad_oe_d;
			core_in_o <= core_in_d;
		end
	end

	highz_pins_a: assert property (all_z |=> pad_oe_o == '0) // see R16
		else $error("pins driven during tristate instruction");
	clamp_drive_a: assert property (drive_bs // see R17
		|=> pad_out_o == $past(upd_out))
		else $error("pins not driven from boundary cells");
	sample_pass_a: assert property (ir_q == `IR_SAMPLE && !id_sel_q // see R15
		|=> core_in_o == $past(pin_s_q))
		else $error("sample disturbed core inputs");

	// Serial output: queued after rise, presented on the next fall
	wire shifting = (st_q == ST_SIR) | (st_q == ST_SDR);
	wire dr_lsb   = sel_id ? id_q[0] : (sel_bsr ? bsr_q[0] : byp_q);
	wire ser_lsb  = (st_q == ST_SIR) ? ir_sh_q[0] : dr_lsb;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
		end else begin
			pend_q <= tck_rise | (pend_q & ~oq_rdy);
		end
	end

	bit_fifo #(
		.W (`OUTQ_W),
		.D (`OUTQ_DEPTH)
	) u_outq (
		.clk       (core_clk),
		.rst_n     (rst_n),
		.in_valid  (pend_q),
		.in_ready  (oq_rdy),
		.in_data   ({shifting, ser_lsb}),
		.out_valid (oq_vld),
		.out_ready (tck_fall),
		.out_data  (oq_dat)
	);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tdo_o    <= 1'b0;
			tdo_oe_o <= 1'b0;
		end else if (tck_fall && oq_vld) begin
			tdo_o    <= oq_dat[0]; // see R11
			tdo_oe_o <= oq_dat[1]; // see R13
		end
	end

	tdo_fall_a: assert property ($changed(tdo_o) |-> $past(tck_fall)) // see R11
		else $error("serial output changed off a falling edge");
	tdo_release_a: assert property ($rose(tdo_oe_o) |-> shifting) // see R13
		else $error("serial output driven outside a shift");

	id_shift_c: cover property (in_shd && sel_id);
	ir_update_c: cover property (step && st_q == ST_UIR);
	extest_upd_c: cover property (step && st_q == ST_UDR && drive_bs);
	tms_reset_c: cover property (tms_run_q == 3'h5);
endmodule // jtag_tap

// ---- jtag_host_model.sv ----
`timescale 1ns/1ps
module jtag_host_model (
	input  wire logic core_clk, // Pacing clock
	input  wire logic tdo,      // Serial data from device
	input  wire logic tdo_oe,   // Device drive enable
	output logic      tck,      // Test clock, still between frames
	output logic      tms,      // Mode select
	output logic      tdi       // Serial data to device
);
	logic oe_bad; // Drive enable wrong during last scan

	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		oe_bad = 1'b0;
	end

	// One 160 ns test clock; tdo read late in the high half
	task automatic step(input logic m, input logic d, output logic so,
		output logic soe);
		tms = m;
		tdi = d;
		repeat (4) @(posedge core_clk);
		#1 tck = 1'b1;
		repeat (4) @(posedge core_clk);
		// Released line reads as the inverse of the last level
		so = tdo_oe ? tdo : ~tdo;
		soe = tdo_oe;
		#1 tck = 1'b0;
	endtask

	// Five rises with mode-select high, then idle
	task automatic tlr();
		logic so, soe;
		repeat (5) step(1'b1, 1'b0, so, soe);
		step(1'b0, 1'b0, so, soe);
	endtask

	// Full scan from idle back to idle, LSB first
	task automatic scan(input logic ir, input logic [31:0] din,
		input int n, output logic [31:0] dout);
		logic so, soe;
		dout = '0;
		oe_bad = 1'b0;
		step(1'b1, 1'b0, so, soe);
		if (ir) begin
			step(1'b1, 1'b0, so, soe);
		end
		step(1'b0, 1'b0, so, soe);
		step(1'b0, 1'b0, so, soe);
		oe_bad |= (soe !== 1'b0);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], so, soe);
			dout[i] = so;
			oe_bad |= (soe !== 1'b1);
		end
		step(1'b1, 1'b0, so, soe);
		oe_bad |= (soe !== 1'b0);
		step(1'b0, 1'b0, so, soe);
		oe_bad |= (soe !== 1'b0);
	endtask
endmodule // jtag_host_model

// ---- tb_jtag_boundary_scan_tap.sv ----
`timescale 1ns/1ps
`include "tap_cfg.svh"
module tb_jtag_boundary_scan_tap;
	import tap_pkg::*;
	logic                 core_clk, resetn, tck, tms, tdi;
	logic                 tdo_o, tdo_oe_o;
	logic [`IO_COUNT-1:0] core_out, core_oe, core_in_o;
	logic [`IO_COUNT-1:0] pad_in, pad_out_o, pad_oe_o;
	logic [31:0]          dout;
	int                   err_total = 0;
	int                   checks_done = 0;
	localparam logic [31:0] id_exp = {`ID_VERSION, `ID_PART,
		`ID_NUMBER, `ID_LOW_BYTE};

	jtag_tap uut (.core_clk(core_clk), .resetn(resetn), .tck(tck),
		.tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
		.core_out(core_out), .core_oe(core_oe), .core_in_o(core_in_o),
		.pad_in(pad_in), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o));

	jtag_host_model host (.core_clk(core_clk), .tdo(tdo_o),
		.tdo_oe(tdo_oe_o), .tck(tck), .tms(tms), .tdi(tdi));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask

	task automatic print_verdict();
		if (err_total == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	function automatic logic [7:0] sel(input logic [23:0] v, input int k);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) r[i] = v[3*i+k];
		return r;
	endfunction

	function automatic logic [23:0] cap_exp();
		logic [23:0] e;
		for (int i = 0; i < 8; i++) begin
			e[3*i+`BSC_IN] = pad_in[i];
			e[3*i+`BSC_OUT] = core_out[i];
			e[3*i+`BSC_OE] = core_oe[i];
		end
		return e;
	endfunction

	task automatic load_ir(input instr_t c);
		host.scan(1'b1, 32'(c), 3, dout);
		chk(32'(dout[2:0]), 32'(`IR_CAPTURE));
		chk(32'(host.oe_bad), 32'h0);
	endtask

	task automatic chk_normal();
		chk(32'(pad_out_o), 32'(core_out));
		chk(32'(pad_oe_o), 32'(core_oe));
		chk(32'(core_in_o), 32'(pad_in));
	endtask

	task automatic chk_cells(input logic [23:0] v);
		chk(32'(pad_out_o), 32'(sel(v, `BSC_OUT)));
		chk(32'(pad_oe_o), 32'(sel(v, `BSC_OE)));
	endtask

	task automatic t_idcode();
		host.tlr();
		chk_normal();
		host.scan(1'b0, 32'h0, 32, dout);
		chk(dout, id_exp);
	endtask

	task automatic t_bypass();
		instr_t codes [4] = '{3'h7, 3'h2, 3'h3, 3'h4};
		foreach (codes[k]) begin
			load_ir(codes[k]);
			host.scan(1'b0, 32'hA5, 8, dout);
			chk(32'(dout[7:0]), 32'h4A);
			chk_normal();
		end
	endtask

	task automatic t_boundary();
		logic [23:0] e;
		load_ir(`IR_SAMPLE);
		e = cap_exp();
		host.scan(1'b0, 32'h009A_3C65, 24, dout);
		chk(32'(dout[23:0]), 32'(e));
		chk_normal();
		load_ir(`IR_EXTEST);
		chk_cells(24'h9A_3C65);
		chk(32'(core_in_o), 32'(sel(24'h9A_3C65, `BSC_IN)));
		pad_in = 8'hA6;
		e = cap_exp();
		host.scan(1'b0, 32'h005C_93A1, 24, dout);
		chk(32'(dout[23:0]), 32'(e));
		chk_cells(24'h5C_93A1);
		load_ir(`IR_CLAMP);
		chk_cells(24'h5C_93A1);
		load_ir(`IR_HIGHZ);
		chk(32'(pad_oe_o), 32'h0);
		host.tlr();
		chk_normal();
	endtask

	task automatic t_tms_reset();
		logic so, soe;
		load_ir(`IR_BYPASS);
		host.step(1'b1, 1'b0, so, soe);
		host.step(1'b0, 1'b0, so, soe);
		host.step(1'b0, 1'b0, so, soe);
		host.step(1'b0, 1'b1, so, soe);
		chk(32'(soe), 32'h1);
		host.tlr();
		chk(32'(tdo_oe_o), 32'h0);
		host.scan(1'b0, 32'h0, 32, dout);
		chk(dout, id_exp);
	endtask

	initial begin
		resetn = 1'b0;
		core_out = 8'h96;
		core_oe = 8'h0F;
		pad_in = 8'h5A;
		repeat (20) @(posedge core_clk);
		#1 resetn = 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		t_idcode();
		t_bypass();
		core_out = 8'h5A;
		core_oe = 8'hC3;
		pad_in = 8'h3C;
		t_boundary();
		t_tms_reset();
		print_verdict();
	end

	initial begin
		#200_000;
		err_total++;
		print_verdict();
	end
endmodule // tb_jtag_boundary_scan_tap
